// File: src/ptei_regs.sv
// Operation
// - writing 1 selects constant latency mode
// - writing 1 selects low power mode
// - supply warning sets its event flag
// - entering cpu sleep sets entry flag
// - leaving cpu sleep sets exit flag
// - enable set register writes 1 enable
// - enable set register reads enable state
// - clear register 1 disables, 0 keeps
// - clear register reads same enable state
module ptei_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [ptei_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ptei_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [ptei_pkg::BE_W-1:0] avs_byteenable,
    output logic [ptei_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // event sources
    input wire logic supply_drop_warning,
    input wire logic cpu_sleeping,
    // power system control
    output ptei_pkg::ptei_mode_t power_mode,
    output logic constant_latency_task,
    output logic low_power_task,
    // interrupt
    output logic irq
);

    // ************************************************************
    // bus handshake
    // ************************************************************
    // one wait state: the answer flop rises the cycle after a request
    // shows up, and the access is committed on the edge the master
    // samples waitrequest low, so a write lands exactly once
    logic ack_q;
    logic ack_d;
    logic req;                                      // any access pending
    logic commit_wr;                                // write taken this edge
    logic lane0;                                    // low byte lane enabled

    assign req = avs_read | avs_write;
    assign ack_d = req & ~ack_q;
    assign commit_wr = avs_write & ack_q;
    assign lane0 = avs_byteenable[ptei_pkg::LANE0];

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic hit_at(input logic [ptei_pkg::ADDR_W-1:0] a,
                                    input logic [ptei_pkg::ADDR_W-1:0] off);
        hit_at = (a == off);
    endfunction

    logic sel_cl;                                   // constant latency trigger
    logic sel_lp;                                   // low power trigger
    logic sel_sw;                                   // supply warning flag
    logic sel_se;                                   // sleep entry flag
    logic sel_sx;                                   // sleep exit flag
    logic sel_es;                                   // enable set
    logic sel_ec;                                   // enable clear

    assign sel_cl = hit_at(avs_address, ptei_pkg::OFF_CONST_LATENCY_TRIGGER);
    assign sel_lp = hit_at(avs_address, ptei_pkg::OFF_LOW_POWER_TRIGGER);
    assign sel_sw = hit_at(avs_address, ptei_pkg::OFF_SUPPLY_WARNING_FLAG);
    assign sel_se = hit_at(avs_address, ptei_pkg::OFF_SLEEP_ENTRY_FLAG);
    assign sel_sx = hit_at(avs_address, ptei_pkg::OFF_SLEEP_EXIT_FLAG);
    assign sel_es = hit_at(avs_address, ptei_pkg::OFF_IRQ_ENABLE_SET_REG);
    assign sel_ec = hit_at(avs_address, ptei_pkg::OFF_IRQ_ENABLE_CLEAR_REG);

    // write strobes, only the low lane carries fields
    logic wr_lane;
    logic wr_bit_trig;
    logic wr_bit_flag;

    assign wr_lane = commit_wr & lane0;
    assign wr_bit_trig = avs_writedata[ptei_pkg::TRIGGER_BIT];
    assign wr_bit_flag = avs_writedata[ptei_pkg::FLAG_BIT];

    // ************************************************************
    // tasks and power mode
    // ************************************************************
    logic cl_fire;                                  // constant latency task fires
    logic lp_fire;                                  // low power task fires
    ptei_pkg::ptei_mode_t mode_q;
    ptei_pkg::ptei_mode_t mode_d;
    logic cl_pulse_q;
    logic lp_pulse_q;

    assign cl_fire = wr_lane & sel_cl & wr_bit_trig;
    assign lp_fire = wr_lane & sel_lp & wr_bit_trig;

    // a zero written to a trigger is a no-op; the two triggers sit at
    // different addresses so they can never fire together
    assign mode_d = cl_fire ? ptei_pkg::PTEI_MODE_CONST_LATENCY :
                    lp_fire ? ptei_pkg::PTEI_MODE_LOW_POWER :
                    mode_q;

    // mode level plus one-cycle task pulses for the regulator logic
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mode_q <= ptei_pkg::PTEI_MODE_LOW_POWER;
            cl_pulse_q <= 1'b0;
            lp_pulse_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            cl_pulse_q <= cl_fire;
            lp_pulse_q <= lp_fire;
        end
    end

    assign power_mode = mode_q;
    assign constant_latency_task = cl_pulse_q;
    assign low_power_task = lp_pulse_q;

    // ************************************************************
    // event flags
    // ************************************************************
    ptei_pkg::ptei_evt_t flags;

    // warning flag: rising edge of the comparator warning
    ptei_event_flag #(
        .FALLING(1'b0)
    ) u_flag_supply (
        .core_clk(core_clk),
        .nrst(nrst),
        .src(supply_drop_warning),
        .sw_we(wr_lane & sel_sw),
        .sw_val(wr_bit_flag),
        .flag_q(flags.supply_warn)
    );

    // entry flag: cpu goes to sleep on a wait instruction
    ptei_event_flag #(
        .FALLING(1'b0)
    ) u_flag_entry (
        .core_clk(core_clk),
        .nrst(nrst),
        .src(cpu_sleeping),
        .sw_we(wr_lane & sel_se),
        .sw_val(wr_bit_flag),
        .flag_q(flags.sleep_entry)
    );

    // exit flag: cpu leaves sleep
    ptei_event_flag #(
        .FALLING(1'b1)
    ) u_flag_exit (
        .core_clk(core_clk),
        .nrst(nrst),
        .src(cpu_sleeping),
        .sw_we(wr_lane & sel_sx),
        .sw_val(wr_bit_flag),
        .flag_q(flags.sleep_exit)
    );

    // ************************************************************
    // interrupt enables
    // ************************************************************
    ptei_pkg::ptei_evt_t en_q;
    ptei_pkg::ptei_evt_t en_d;
    ptei_pkg::ptei_evt_t wr_fields;                 // write data as event fields
    ptei_pkg::ptei_evt_t set_mask;
    ptei_pkg::ptei_evt_t clr_mask;

    assign wr_fields.supply_warn = avs_writedata[ptei_pkg::EN_SUPPLY_BIT];
    assign wr_fields.sleep_entry = avs_writedata[ptei_pkg::EN_ENTRY_BIT];
    assign wr_fields.sleep_exit = avs_writedata[ptei_pkg::EN_EXIT_BIT];

    assign set_mask = (wr_lane & sel_es) ? wr_fields : ptei_pkg::EVT_NONE;
    assign clr_mask = (wr_lane & sel_ec) ? wr_fields : ptei_pkg::EVT_NONE;

    // zeros in either mask leave the enable alone
    assign en_d = (en_q | set_mask) & ~clr_mask;

    // enable bits
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            en_q <= ptei_pkg::EVT_NONE;
        end else begin
            en_q <= en_d;
        end
    end

    // ************************************************************
    // interrupt output
    // ************************************************************
    // registered so the pin comes from a flop; it trails the flags by
    // one cycle, which software never sees as a glitch
    logic irq_q;
    logic irq_d;

    assign irq_d = |(flags & en_q);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irq = irq_q;

    // ************************************************************
    // read mux
    // ************************************************************
    logic [ptei_pkg::DATA_W-1:0] en_word;           // enables placed at their fields
    logic [ptei_pkg::DATA_W-1:0] rd_word;

    always_comb begin
        en_word = ptei_pkg::RESET_WORD;
        en_word[ptei_pkg::EN_SUPPLY_BIT] = en_q.supply_warn;
        en_word[ptei_pkg::EN_ENTRY_BIT] = en_q.sleep_entry;
        en_word[ptei_pkg::EN_EXIT_BIT] = en_q.sleep_exit;
    end

    // triggers are write-only and read back as zero, like unmapped space
    assign rd_word =
        sel_sw ? {{(ptei_pkg::DATA_W-1){1'b0}}, flags.supply_warn} :
        sel_se ? {{(ptei_pkg::DATA_W-1){1'b0}}, flags.sleep_entry} :
        sel_sx ? {{(ptei_pkg::DATA_W-1){1'b0}}, flags.sleep_exit} :
        (sel_es | sel_ec) ? en_word :
        ptei_pkg::UNMAPPED_WORD;

    // ************************************************************
    // bus answer flops
    // ************************************************************
    logic [ptei_pkg::DATA_W-1:0] rdata_q;
    logic [ptei_pkg::DATA_W-1:0] rdata_d;

    // data is captured with the ack so it stands on the sampling edge
    assign rdata_d = (avs_read & ~ack_q) ? rd_word : rdata_q;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            rdata_q <= ptei_pkg::RESET_WORD;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = ~ack_q;

endmodule

// File: src/ptei_pkg.sv
package ptei_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 12;                     // byte address, one word per register
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFF_CONST_LATENCY_TRIGGER = 12'h078;
    localparam logic [ADDR_W-1:0] OFF_LOW_POWER_TRIGGER = 12'h07c;
    localparam logic [ADDR_W-1:0] OFF_SUPPLY_WARNING_FLAG = 12'h108;
    localparam logic [ADDR_W-1:0] OFF_SLEEP_ENTRY_FLAG = 12'h114;
    localparam logic [ADDR_W-1:0] OFF_SLEEP_EXIT_FLAG = 12'h118;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_SET_REG = 12'h304;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_CLEAR_REG = 12'h308;

    // ************************************************************
    // field positions and values
    // ************************************************************
    localparam int TRIGGER_BIT = 0;                 // task trigger field
    localparam int FLAG_BIT = 0;                    // event flag field
    localparam int EN_SUPPLY_BIT = 0;               // enable field of the warning event
    localparam int EN_ENTRY_BIT = 1;                // enable field of the sleep entry event
    localparam int EN_EXIT_BIT = 2;                 // enable field of the sleep exit event
    localparam int LANE0 = 0;                       // byte lane holding every field
    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
    localparam logic [DATA_W-1:0] UNMAPPED_WORD = 32'h0000_0000;

    // ************************************************************
    // carriers
    // ************************************************************
    // one bit per event, same layout for flags and enables
    typedef struct packed {
        logic sleep_exit;
        logic sleep_entry;
        logic supply_warn;
    } ptei_evt_t;

    localparam ptei_evt_t EVT_NONE = 3'h0;

    // power system operating mode
    typedef enum logic {
        PTEI_MODE_LOW_POWER,
        PTEI_MODE_CONST_LATENCY
    } ptei_mode_t;

endpackage

// File: src/ptei_event_flag.sv
// ************************************************************
// one sticky event flag with an edge detecting source
// ************************************************************
module ptei_event_flag #(
    parameter bit FALLING = 1'b0                    // 1: event is the falling edge of src
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // event source, a level
    input wire logic src,
    // software access
    input wire logic sw_we,
    input wire logic sw_val,
    // flag state
    output logic flag_q
);

    logic src_q;                                    // source one cycle back
    logic hit;                                      // edge seen this cycle
    logic flag_d;

    // edge decode on the selected polarity
    assign hit = FALLING ? (src_q & ~src) : (~src_q & src);

    // hardware set wins over a software clear in the same cycle
    assign flag_d = hit ? 1'b1 : (sw_we ? sw_val : flag_q);

    // flag and edge history
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            src_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            src_q <= src;
            flag_q <= flag_d;
        end
    end

endmodule

// File: dv/ptei_regs_properties.sv
// ****
// bus, task and interrupt timing seen at the block's pins
// ****
module ptei_regs_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register bus
    input wire logic [ptei_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ptei_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [ptei_pkg::BE_W-1:0] avs_byteenable,
    input wire logic [ptei_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    // events and outputs
    input wire logic supply_drop_warning,
    input wire logic cpu_sleeping,
    input wire ptei_pkg::ptei_mode_t power_mode,
    input wire logic constant_latency_task,
    input wire logic low_power_task,
    input wire logic irq
);
    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // commit edge of a request; only lane 0 carries fields
    wire commit = (avs_read || avs_write) && !avs_waitrequest;
    wire wr_en = commit && avs_write && avs_byteenable[0];
    wire at_cl = avs_address == ptei_pkg::OFF_CONST_LATENCY_TRIGGER;
    wire at_lp = avs_address == ptei_pkg::OFF_LOW_POWER_TRIGGER;
    wire wr_cl = wr_en && at_cl && avs_writedata[0];
    wire wr_lp = wr_en && at_lp && avs_writedata[0];
    // clearing every enable must silence the line whatever the flags hold
    wire clr_all = wr_en && avs_writedata[2:0] == 3'h7
        && avs_address == ptei_pkg::OFF_IRQ_ENABLE_CLEAR_REG;

    a_one_wait_state: assert property (
        (avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest)
        |=> !avs_waitrequest) else $error("request not answered after one wait state");
    a_ack_one_cycle: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
    a_const_task: assert property (
        wr_cl |=> constant_latency_task && power_mode == ptei_pkg::PTEI_MODE_CONST_LATENCY
        ##1 !constant_latency_task) else $error("constant latency trigger wrong");
    a_lowpwr_task: assert property (
        wr_lp |=> low_power_task && power_mode == ptei_pkg::PTEI_MODE_LOW_POWER
        ##1 !low_power_task) else $error("low power trigger wrong");
    a_task_cause: assert property (
        constant_latency_task || low_power_task |-> $past(wr_cl) || $past(wr_lp))
        else $error("task pulse without a trigger write");
    a_mode_cause: assert property (
        power_mode != $past(power_mode) |-> $past(wr_cl) || $past(wr_lp))
        else $error("mode moved without a trigger write");
    a_task_read_zero: assert property (
        commit && avs_read && (at_cl || at_lp) |-> avs_readdata == 32'h0)
        else $error("trigger register read not zero");
    a_irq_off_clear: assert property (
        clr_all |=> ##1 !irq) else $error("interrupt stayed after enables cleared");

    c_const_task: cover property (wr_cl);
    c_irq_rise: cover property ($rose(irq));
    c_clear_all: cover property (clr_all);
endmodule

// File: dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // stimulus, design and shared bus tasks
    // ****
    localparam logic [11:0] A_CL = ptei_pkg::OFF_CONST_LATENCY_TRIGGER;
    localparam logic [11:0] A_LP = ptei_pkg::OFF_LOW_POWER_TRIGGER;
    localparam logic [11:0] A_WN = ptei_pkg::OFF_SUPPLY_WARNING_FLAG;
    localparam logic [11:0] A_EN = ptei_pkg::OFF_SLEEP_ENTRY_FLAG;
    localparam logic [11:0] A_EX = ptei_pkg::OFF_SLEEP_EXIT_FLAG;
    localparam logic [11:0] A_SET = ptei_pkg::OFF_IRQ_ENABLE_SET_REG;
    localparam logic [11:0] A_CLR = ptei_pkg::OFF_IRQ_ENABLE_CLEAR_REG;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] avs_address = 12'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic supply_drop_warning = 1'b0;
    logic cpu_sleeping = 1'b0;
    ptei_pkg::ptei_mode_t power_mode;
    logic constant_latency_task;
    logic low_power_task;
    logic irq;
    int num_errors = 0;
    int checks = 0;

    always #5 core_clk = ~core_clk;

    ptei_regs dut (.core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .supply_drop_warning,
        .cpu_sleeping, .power_mode, .constant_latency_task, .low_power_task, .irq);

    task automatic summarize();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one transfer; request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        // sample waitrequest at each rising edge; the edge that sees it low
        // commits the access, takes the read data and only then releases
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            num_errors++;
            summarize();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        check(what, exp, q);
    endtask

    // let n edges land, then look once the outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // ****
    // scenarios
    // ****
    task automatic s_reset_values();
        rd("warn flag", A_WN, 32'h0);
        rd("entry flag", A_EN, 32'h0);
        rd("exit flag", A_EX, 32'h0);
        rd("enable set", A_SET, 32'h0);
        rd("enable clr", A_CLR, 32'h0);
        check("mode", 32'h0, 32'(power_mode));
        check("irq", 32'h0, 32'(irq));
    endtask

    // back and forth between modes; a zero write must not move the mode
    task automatic s_tasks();
        wr(A_CL, 32'h1);
        #1;
        check("cl pulse", 32'h1, 32'(constant_latency_task));
        check("mode", 32'h1, 32'(power_mode));
        tick(1);
        check("cl pulse end", 32'h0, 32'(constant_latency_task));
        wr(A_LP, 32'h1);
        #1;
        check("lp pulse", 32'h1, 32'(low_power_task));
        check("mode", 32'h0, 32'(power_mode));
        wr(A_CL, 32'hffff_fffe);
        tick(1);
        check("mode", 32'h0, 32'(power_mode));
        rd("cl read", A_CL, 32'h0);
        rd("lp read", A_LP, 32'h0);
    endtask

    task automatic s_events();
        wr(A_SET, 32'h7);
        rd("enable set", A_SET, 32'h7);
        rd("enable clr", A_CLR, 32'h7);
        supply_drop_warning <= 1'b1;
        tick(3);
        check("irq", 32'h1, 32'(irq));
        rd("warn flag", A_WN, 32'h1);
        wr(A_WN, 32'h0);
        tick(2);
        check("irq", 32'h0, 32'(irq));
        supply_drop_warning <= 1'b0;
        cpu_sleeping <= 1'b1;
        tick(3);
        rd("entry flag", A_EN, 32'h1);
        rd("exit flag", A_EX, 32'h0);
        wr(A_EN, 32'h0);
        cpu_sleeping <= 1'b0;
        tick(3);
        rd("exit flag", A_EX, 32'h1);
        wr(A_EX, 32'h0);
        tick(2);
        check("irq", 32'h0, 32'(irq));
    endtask

    // partial clear, a masked event, then a clear of all with a flag still up
    task automatic s_clear();
        wr(A_CLR, 32'h2);
        rd("enable set", A_SET, 32'h5);
        rd("enable clr", A_CLR, 32'h5);
        cpu_sleeping <= 1'b1;
        tick(3);
        check("masked irq", 32'h0, 32'(irq));
        wr(A_EN, 32'h0);
        cpu_sleeping <= 1'b0;
        tick(3);
        check("irq", 32'h1, 32'(irq));
        wr(A_CLR, 32'h7);
        tick(2);
        check("irq", 32'h0, 32'(irq));
        rd("enable set", A_SET, 32'h0);
        wr(A_EX, 32'h0);
    endtask

    task automatic s_refused();
        logic [31:0] q;
        wr(12'h200, 32'hffff_ffff);
        rd("unmapped", 12'h200, 32'h0);
        bus(1'b1, A_SET, 32'h7, 4'h0, q);
        rd("enable set", A_SET, 32'h0);
    endtask

    task automatic s_mid_reset();
        wr(A_SET, 32'h7);
        wr(A_CL, 32'h1);
        nrst <= 1'b0;
        tick(3);
        nrst <= 1'b1;
        rd("enable set", A_SET, 32'h0);
        check("mode", 32'h0, 32'(power_mode));
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        s_reset_values();
        s_tasks();
        s_events();
        s_clear();
        s_refused();
        s_mid_reset();
        summarize();
    end

    // cut a hang short
    initial begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        summarize();
    end
endmodule

bind ptei_regs ptei_regs_properties u_props (.core_clk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .supply_drop_warning, .cpu_sleeping, .power_mode, .constant_latency_task,
    .low_power_task, .irq);
